// ### core/bsf_pkg.sv
/*
 bsf_pkg: register map, status flag positions, reset values and op codes
 of the bit, shift and flag unit.
 assumes an AXI4-Lite master with 32-bit data and one clock.
*/
// Summary of operation
// - logical left shift moves bits up one, zero into bit zero
// - logical right shift moves bits down one, zero into bit seven
// - left rotate: old carry into bit zero, old bit seven into carry
// - right rotate: old carry into bit seven, old bit zero into carry
// - arithmetic right shift moves bits down, bit seven stays as sign
// - nibble swap exchanges upper and lower four bits at once
// - generic flag set forces selected status bit one, clear forces zero
// - bit store copies selected operand bit into the transfer flag
// - bit load copies transfer flag into selected bit, others kept
// - each named flag has own set and clear touching only it
// - global interrupt enable sets, disable clears the interrupt flag
// - I/O bit clear zeroes the selected bit, other bits kept
package bsf_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int SEL_W  = 3;
    localparam int OP_W   = 5;

    localparam logic [ADDR_W-1:0] ADDR_OPERAND = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IOREG   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CMD     = 8'h0C;

    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_SEL_LSB = 8;
    localparam logic [3:0] CMD_STRB = 4'h3;

    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [REG_W-1:0] RST_OPERAND = 8'h00;
    localparam logic [REG_W-1:0] RST_STATUS  = 8'h00;
    localparam logic [REG_W-1:0] RST_IOREG   = 8'h00;
    localparam logic [REG_W-1:0] BIT_ONE     = 8'h01;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [OP_W-1:0] {
        SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL, ROTATE_LEFT_CARRY, ROTATE_RIGHT_CARRY,
        SHIFT_RIGHT_ARITH, SWAP_NIBBLES, FLAG_SET_GENERIC, FLAG_CLEAR_GENERIC,
        STORE_BIT_TO_TRANSFER, LOAD_BIT_FROM_TRANSFER, SET_IO_BIT, CLEAR_IO_BIT,
        SET_CARRY_OP, CLEAR_CARRY_OP, SET_NEGATIVE_OP, CLEAR_NEGATIVE_OP,
        SET_ZERO_OP, CLEAR_ZERO_OP, SET_SIGNED_OP, CLEAR_SIGNED_OP,
        SET_OVERFLOW_OP, CLEAR_OVERFLOW_OP, SET_TRANSFER_OP, CLEAR_TRANSFER_OP,
        SET_HALF_CARRY_OP, CLEAR_HALF_CARRY_OP, GLOBAL_IRQ_ENABLE_OP, GLOBAL_IRQ_DISABLE_OP
    } op_t;
endpackage

// ### core/bit_shift_flag_unit.sv
/*
 bit_shift_flag_unit: 8-bit shift/rotate/swap datapath with status flag
 and single-bit operations, reached over an AXI4-Lite slave.
 assumes one clock, synchronous active-high reset, one outstanding write
 and one outstanding read from the master.
*/
`timescale 1ns/10ps
module bit_shift_flag_unit (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [bsf_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic [2:0]                   awprot,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [bsf_pkg::DATA_W-1:0]   wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [bsf_pkg::ADDR_W-1:0]   araddr,
    input  wire logic [2:0]                   arprot,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [bsf_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    output logic                              irqEnable
);
    import bsf_pkg::*;

    logic [REG_W-1:0]  operand_q;
    logic [REG_W-1:0]  status_q;
    logic [REG_W-1:0]  ioReg_q;
    logic [REG_W-1:0]  operand_d;
    logic [REG_W-1:0]  status_d;
    logic [REG_W-1:0]  ioReg_d;
    op_t               opCode_q;
    logic [SEL_W-1:0]  bitSel_q;
    logic              execPend_q;
    logic              wrFire;
    logic              rdFire;
    logic [ADDR_W-1:0] wrOff;
    logic [ADDR_W-1:0] rdOff;
    logic              arith;
    logic [REG_W-1:0]  selMask;

    ////////////////////////////////////////////////////////////////////////////
    // write channel: address and data are taken together in one edge
    assign wrOff   = {awaddr[ADDR_W-1:2], 2'h0};
    // writes and reads are held off while a command executes so that the
    // datapath is the only writer of the registers in that cycle
    assign wrFire  = awvalid && wvalid && !bvalid && !execPend_q;
    assign awready = wrFire;
    assign wready  = wrFire;

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid <= 1'h0;
            bresp  <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'h1;
            if (wrOff == ADDR_OPERAND || wrOff == ADDR_STATUS ||
                wrOff == ADDR_IOREG || wrOff == ADDR_CMD) begin
                bresp <= RESP_OKAY;
            end else begin
                bresp <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command capture: the op runs in the cycle after the write is taken
    always_ff @(posedge clk) begin
        if (rst) begin
            opCode_q   <= SHIFT_LEFT_LOGICAL;
            bitSel_q   <= 3'h0;
            execPend_q <= 1'h0;
        end else if (wrFire && wrOff == ADDR_CMD && (wstrb & CMD_STRB) == CMD_STRB) begin
            opCode_q   <= op_t'(wdata[CMD_OP_LSB +: OP_W]);
            bitSel_q   <= wdata[CMD_SEL_LSB +: SEL_W];
            execPend_q <= 1'h1;
        end else begin
            execPend_q <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // datapath
    assign selMask = BIT_ONE << bitSel_q;

    always_comb begin
        operand_d = operand_q;
        status_d  = status_q;
        ioReg_d   = ioReg_q;
        arith     = 1'h0;
        case (opCode_q)
            SHIFT_LEFT_LOGICAL: begin
                operand_d        = {operand_q[6:0], 1'h0};
                status_d[FLAG_C] = operand_q[7];
                arith            = 1'h1;
            end
            SHIFT_RIGHT_LOGICAL: begin
                operand_d        = {1'h0, operand_q[7:1]};
                status_d[FLAG_C] = operand_q[0];
                arith            = 1'h1;
            end
            ROTATE_LEFT_CARRY: begin
                operand_d        = {operand_q[6:0], status_q[FLAG_C]};
                status_d[FLAG_C] = operand_q[7];
                arith            = 1'h1;
            end
            ROTATE_RIGHT_CARRY: begin
                operand_d        = {status_q[FLAG_C], operand_q[7:1]};
                status_d[FLAG_C] = operand_q[0];
                arith            = 1'h1;
            end
            SHIFT_RIGHT_ARITH: begin
                operand_d        = {operand_q[7], operand_q[7:1]};
                status_d[FLAG_C] = operand_q[0];
                arith            = 1'h1;
            end
            SWAP_NIBBLES: begin
                operand_d = {operand_q[3:0], operand_q[7:4]};
                arith     = 1'h1;
            end
            FLAG_SET_GENERIC:       status_d = status_q | selMask;
            FLAG_CLEAR_GENERIC:     status_d = status_q & ~selMask;
            STORE_BIT_TO_TRANSFER:  status_d[FLAG_T] = operand_q[bitSel_q];
            LOAD_BIT_FROM_TRANSFER: operand_d[bitSel_q] = status_q[FLAG_T];
            SET_IO_BIT:             ioReg_d = ioReg_q | selMask;
            CLEAR_IO_BIT:           ioReg_d = ioReg_q & ~selMask;
            SET_CARRY_OP:           status_d[FLAG_C] = 1'h1;
            CLEAR_CARRY_OP:         status_d[FLAG_C] = 1'h0;
            SET_NEGATIVE_OP:        status_d[FLAG_N] = 1'h1;
            CLEAR_NEGATIVE_OP:      status_d[FLAG_N] = 1'h0;
            SET_ZERO_OP:            status_d[FLAG_Z] = 1'h1;
            CLEAR_ZERO_OP:          status_d[FLAG_Z] = 1'h0;
            SET_SIGNED_OP:          status_d[FLAG_S] = 1'h1;
            CLEAR_SIGNED_OP:        status_d[FLAG_S] = 1'h0;
            SET_OVERFLOW_OP:        status_d[FLAG_V] = 1'h1;
            CLEAR_OVERFLOW_OP:      status_d[FLAG_V] = 1'h0;
            SET_TRANSFER_OP:        status_d[FLAG_T] = 1'h1;
            CLEAR_TRANSFER_OP:      status_d[FLAG_T] = 1'h0;
            SET_HALF_CARRY_OP:      status_d[FLAG_H] = 1'h1;
            CLEAR_HALF_CARRY_OP:    status_d[FLAG_H] = 1'h0;
            GLOBAL_IRQ_ENABLE_OP:   status_d[FLAG_I] = 1'h1;
            GLOBAL_IRQ_DISABLE_OP:  status_d[FLAG_I] = 1'h0;
            default: begin
            end
        endcase
        // overflow follows the usual shift convention: negative xor carry
        if (arith) begin
            status_d[FLAG_Z] = (operand_d == 8'h00);
            status_d[FLAG_N] = operand_d[7];
            status_d[FLAG_V] = status_d[FLAG_N] ^ status_d[FLAG_C];
            status_d[FLAG_S] = status_d[FLAG_N] ^ status_d[FLAG_V];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage: execution has priority, bus writes are blocked then
    always_ff @(posedge clk) begin
        if (rst) begin
            operand_q <= RST_OPERAND;
        end else if (execPend_q) begin
            operand_q <= operand_d;
        end else if (wrFire && wrOff == ADDR_OPERAND && wstrb[0]) begin
            operand_q <= wdata[REG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= RST_STATUS;
        end else if (execPend_q) begin
            status_q <= status_d;
        end else if (wrFire && wrOff == ADDR_STATUS && wstrb[0]) begin
            status_q <= wdata[REG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ioReg_q <= RST_IOREG;
        end else if (execPend_q) begin
            ioReg_q <= ioReg_d;
        end else if (wrFire && wrOff == ADDR_IOREG && wstrb[0]) begin
            ioReg_q <= wdata[REG_W-1:0];
        end
    end

    assign irqEnable = status_q[FLAG_I];

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    assign rdOff   = {araddr[ADDR_W-1:2], 2'h0};
    assign arready = !rvalid && !execPend_q;
    assign rdFire  = arvalid && arready;

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'h0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'h1;
            rresp  <= RESP_OKAY;
            case (rdOff)
                ADDR_OPERAND: rdata <= {24'h00_0000, operand_q};
                ADDR_STATUS:  rdata <= {24'h00_0000, status_q};
                ADDR_IOREG:   rdata <= {24'h00_0000, ioReg_q};
                ADDR_CMD:     rdata <= {21'h00_0000, bitSel_q, 3'h0, opCode_q};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks: helpers hold the state seen by the executing cycle
    logic [REG_W-1:0] prevOp_q;
    logic [REG_W-1:0] prevSt_q;
    logic [REG_W-1:0] prevIo_q;
    logic [SEL_W-1:0] prevSel_q;
    logic             prevExec_q;
    op_t              prevCode_q;

    always_ff @(posedge clk) begin
        prevOp_q   <= operand_q;
        prevSt_q   <= status_q;
        prevIo_q   <= ioReg_q;
        prevSel_q  <= bitSel_q;
        prevCode_q <= opCode_q;
        prevExec_q <= rst ? 1'h0 : execPend_q;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_shl_result: assert property (prevExec_q && prevCode_q == SHIFT_LEFT_LOGICAL
        |-> operand_q == {prevOp_q[6:0], 1'h0})
        else $error("logical left shift result wrong");
    a_shr_result: assert property (prevExec_q && prevCode_q == SHIFT_RIGHT_LOGICAL
        |-> operand_q == {1'h0, prevOp_q[7:1]})
        else $error("logical right shift result wrong");
    a_rol_carry: assert property (prevExec_q && prevCode_q == ROTATE_LEFT_CARRY
        |-> operand_q == {prevOp_q[6:0], prevSt_q[FLAG_C]} && status_q[FLAG_C] == prevOp_q[7])
        else $error("left rotate through carry wrong");
    a_ror_carry: assert property (execPend_q && opCode_q == ROTATE_RIGHT_CARRY
        |=> operand_q == {$past(status_q[FLAG_C]), prevOp_q[7:1]}
            && status_q[FLAG_C] == prevOp_q[0])
        else $error("right rotate through carry wrong");
    a_asr_sign: assert property (prevExec_q && prevCode_q == SHIFT_RIGHT_ARITH
        |-> operand_q[7] == prevOp_q[7] && operand_q[6:0] == prevOp_q[7:1])
        else $error("arithmetic shift lost sign or bits");
    a_swap_nibble: assert property (prevExec_q && prevCode_q == SWAP_NIBBLES
        |-> operand_q[3:0] == prevOp_q[7:4] && operand_q[7:4] == prevOp_q[3:0])
        else $error("nibble swap wrong");
    a_flag_generic: assert property (prevExec_q && (prevCode_q == FLAG_SET_GENERIC
        || prevCode_q == FLAG_CLEAR_GENERIC)
        |-> status_q[prevSel_q] == (prevCode_q == FLAG_SET_GENERIC)
            && (status_q | (BIT_ONE << prevSel_q)) == (prevSt_q | (BIT_ONE << prevSel_q)))
        else $error("generic flag op wrong");
    a_store_bit: assert property (prevExec_q && prevCode_q == STORE_BIT_TO_TRANSFER
        |-> status_q[FLAG_T] == prevOp_q[prevSel_q] && operand_q == prevOp_q)
        else $error("bit store to transfer flag wrong");
    a_load_bit: assert property (prevExec_q && prevCode_q == LOAD_BIT_FROM_TRANSFER
        |-> operand_q[prevSel_q] == prevSt_q[FLAG_T]
            && (operand_q | (BIT_ONE << prevSel_q)) == (prevOp_q | (BIT_ONE << prevSel_q)))
        else $error("bit load from transfer flag wrong");
    a_carry_only: assert property (prevExec_q && prevCode_q == SET_CARRY_OP
        |-> status_q == (prevSt_q | (BIT_ONE << FLAG_C)))
        else $error("carry set touched other flags");
    a_half_only: assert property (prevExec_q && prevCode_q == CLEAR_HALF_CARRY_OP
        |-> status_q == (prevSt_q & ~(BIT_ONE << FLAG_H)))
        else $error("half carry clear touched other flags");
    a_irq_flag: assert property (execPend_q && opCode_q == GLOBAL_IRQ_ENABLE_OP
        |=> irqEnable ##1 (irqEnable || $past(wrFire)))
        else $error("global interrupt flag not set");
    a_io_clear: assert property (prevExec_q && prevCode_q == CLEAR_IO_BIT
        |-> ioReg_q == (prevIo_q & ~(BIT_ONE << prevSel_q)))
        else $error("I/O bit clear wrong");
    a_shift_flags: assert property (prevExec_q && prevCode_q <= SWAP_NIBBLES
        |-> status_q[FLAG_Z] == (operand_q == 8'h00) && status_q[FLAG_N] == operand_q[7]
            && status_q[FLAG_V] == (status_q[FLAG_N] ^ status_q[FLAG_C]))
        else $error("zero, negative or overflow flag wrong after shift");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped before taken");

    c_rotate_carry: cover property (execPend_q && opCode_q == ROTATE_LEFT_CARRY
        && status_q[FLAG_C]);
    c_io_clear: cover property (execPend_q && opCode_q == CLEAR_IO_BIT && ioReg_q != 8'h00);
    c_write_read: cover property (wrFire && awaddr == ADDR_CMD ##[2:6] rdFire);
endmodule

// ### sim/axi_lite_master_model.sv
/*
 axi_lite_master_model: AXI4-Lite master that stands in for the decoder side
 of the bit, shift and flag unit; tasks are called from the bench.
 assumes a slave on the same clk that answers every request it takes.
*/
`timescale 1ns/10ps
module axi_lite_master_model (
    input  wire logic                       clk,
    output logic [bsf_pkg::ADDR_W-1:0]      awaddr,
    output logic [2:0]                      awprot,
    output logic                            awvalid,
    input  wire logic                       awready,
    output logic [bsf_pkg::DATA_W-1:0]      wdata,
    output logic [3:0]                      wstrb,
    output logic                            wvalid,
    input  wire logic                       wready,
    input  wire logic [1:0]                 bresp,
    input  wire logic                       bvalid,
    output logic                            bready,
    output logic [bsf_pkg::ADDR_W-1:0]      araddr,
    output logic [2:0]                      arprot,
    output logic                            arvalid,
    input  wire logic                       arready,
    input  wire logic [bsf_pkg::DATA_W-1:0] rdata,
    input  wire logic [1:0]                 rresp,
    input  wire logic                       rvalid,
    output logic                            rready
);
    import bsf_pkg::*;

    initial begin
        {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arprot, arvalid, rready} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // each channel lets go at the very edge that takes it, never earlier;
    // lag holds back the response ready to model a slow consumer
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [3:0] s, input int lag, output logic [1:0] resp,
                         output bit ok);
        ok   = 1'b0;
        resp = RESP_SLVERR;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= (lag == 0);
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                resp = bresp;
                ok   = 1'b1;
            end else if (n + 1 >= lag) begin
                bready <= 1'b1;
            end
        end
    endtask

    task automatic read(input logic [ADDR_W-1:0] a, input int lag,
                        output logic [DATA_W-1:0] d, output logic [1:0] resp, output bit ok);
        ok   = 1'b0;
        d    = '0;
        resp = RESP_SLVERR;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= (lag == 0);
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                d    = rdata;
                resp = rresp;
                ok   = 1'b1;
            end else if (n + 1 >= lag) begin
                rready <= 1'b1;
            end
        end
    endtask
endmodule

// ### sim/tb.sv
/*
 tb: self-checking bench for bit_shift_flag_unit with random operands and ops.
 assumes the master model drives every bus input of the unit.
*/
`timescale 1ns/10ps
module tb;
    import bsf_pkg::*;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, irqEnable;
    logic arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [2:0]        awprot, arprot;
    logic [DATA_W-1:0] wdata, rdata, got;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, resp;
    logic [31:0]       seed;
    int                errors;
    int                compares;

    bit_shift_flag_unit dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .irqEnable(irqEnable));
    axi_lite_master_model m (.clk(clk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected {operand, status, io} after one command
    function automatic logic [23:0] model_op(input logic [4:0] op, input logic [2:0] s,
            input logic [7:0] d, input logic [7:0] st, input logic [7:0] io);
        logic c;
        int   pos [8] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_S, FLAG_V, FLAG_T, FLAG_H, FLAG_I};
        c = st[FLAG_C];
        case (op)
            5'h0: begin c = d[7]; d = {d[6:0], 1'b0}; end
            5'h1: begin c = d[0]; d = {1'b0, d[7:1]}; end
            5'h2: begin c = d[7]; d = {d[6:0], st[FLAG_C]}; end
            5'h3: begin c = d[0]; d = {st[FLAG_C], d[7:1]}; end
            5'h4: begin c = d[0]; d = {d[7], d[7:1]}; end
            5'h5: d = {d[3:0], d[7:4]};
            5'h6: st[s] = 1'b1;
            5'h7: st[s] = 1'b0;
            5'h8: st[FLAG_T] = d[s];
            5'h9: d[s] = st[FLAG_T];
            5'hA: io[s] = 1'b1;
            5'hB: io[s] = 1'b0;
            default: if (op < 5'h1C) st[pos[(op - 5'hC) >> 1]] = ~op[0];
        endcase
        if (op < 5'h6) begin
            st[FLAG_C] = c;
            st[FLAG_Z] = (d == 8'h00);
            st[FLAG_N] = d[7];
            st[FLAG_V] = d[7] ^ c;
            st[FLAG_S] = st[FLAG_N] ^ st[FLAG_V];
        end
        return {d, st, io};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        bit ok;
        m.write(a, d, s, int'(rnd() % 32'h3), resp, ok);
        if (!ok) begin
            errors++;
            conclude();
        end
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        bit ok;
        m.read(a, int'(rnd() % 32'h3), got, resp, ok);
        if (!ok) begin
            errors++;
            conclude();
        end
    endtask

    task automatic reset_and_check();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_OPERAND);
        check(got, 32'(RST_OPERAND));
        rd(ADDR_STATUS);
        check(got, 32'(RST_STATUS));
        rd(ADDR_IOREG);
        check(got, 32'(RST_IOREG));
        check(32'(irqEnable), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [31:0] r2;
        logic [23:0] e;
        logic [4:0]  op;
        logic [2:0]  s;
        errors   = 0;
        compares = 0;
        seed     = 32'hE6F8269C;
        rst      = 1'b1;
        reset_and_check();
        rd(8'h10);
        check({got[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(8'h14, rnd(), 4'hF);
        check(32'(resp), 32'(RESP_SLVERR));
        // strobes that miss the live bytes must leave state alone
        wr(ADDR_STATUS, 32'h000000FF, 4'h0);
        wr(ADDR_CMD, 32'(SET_CARRY_OP), 4'h1);
        rd(ADDR_STATUS);
        check(got, 32'h0);
        for (int i = 0; i < 160; i++) begin
            r  = rnd();
            r2 = rnd();
            op = (i < 32) ? 5'(i) : r[4:0];
            s  = r[10:8];
            if (i % 3 == 0) r[23:16] = {r[0], 7'h00};
            e = model_op(op, s, r[23:16], r[31:24], r2[7:0]);
            wr(ADDR_OPERAND, {24'h0, r[23:16]}, 4'hF);
            wr(ADDR_STATUS, {24'h0, r[31:24]}, 4'hF);
            wr(ADDR_IOREG, {24'h0, r2[7:0]}, 4'hF);
            wr(ADDR_CMD, {21'h0, s, 3'h0, op}, CMD_STRB);
            check(32'(resp), 32'(RESP_OKAY));
            rd(ADDR_OPERAND);
            check(got, {24'h0, e[23:16]});
            rd(ADDR_STATUS);
            check(got, {24'h0, e[15:8]});
            rd(ADDR_IOREG);
            check(got, {24'h0, e[7:0]});
            check(32'(irqEnable), 32'(e[8 + FLAG_I]));
            // the command register reads back the last accepted op and bit
            rd(ADDR_CMD);
            check(got, {21'h0, s, 3'h0, op});
        end
        reset_and_check();
        conclude();
    end
endmodule
